// *** ssp_pkg.sv ***
// shared constants, field layout and carrier types of the serial port
// assumes one core clock and an Avalon-MM register slave in front
//
// How it works
// R1: enable bit hands pins to serial port
// R2: software disables before rewriting the configuration
// R3: software sets pin directions per mode
// R4: serial-in direction handled by port itself
// R5: shift on programmed edge, capture opposite
// R6: master transfer starts on buffer write
// R7: master keeps receiving with serial-out off
// R8: idle polarity sets resting clock level
// R9: most significant bit goes first
// R10: master rate: div 4, 16, 64, timer
// R11: edge select set: first bit early
// R12: slave shifts on external clock pulses
// R13: slave path runs without master clocks
// R14: external clock idles before slave enable
// R15: select pin used only in mode 0100
// R16: select high floats serial-out at once
// R17: select high or disable clears bit count
// R18: slave with edge select needs select
// R19: serial-out as input stops transmission
// R20: master transfer freezes during sleep
// R21: device reset disables port, aborts transfer
// R22: standard modes map to polarity and edge
// R23: mode field encodes rates and slave kinds
// R24: sample phase picks middle or end
// R25: write while busy ignored, collision flag
// R26: slave byte onto full buffer: overflow
// R27: buffer, full bit, done flag together
// R28: timer rate toggles clock per match
package ssp_pkg;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [4:0] OFS_BUFFER  = 5'h00;
  localparam logic [4:0] OFS_CONTROL = 5'h04;
  localparam logic [4:0] OFS_STATUS  = 5'h08;
  localparam logic [4:0] OFS_PINS    = 5'h0C;
  localparam logic [4:0] OFS_EVENT   = 5'h10;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CTL_WRITE_COLLISION_FLAG  = 7;
  localparam int CTL_OVF   = 6;
  localparam int CTL_EN    = 5;
  localparam int CTL_CKP   = 4;
  localparam int STS_SMP   = 7;
  localparam int STS_CKE   = 6;
  localparam int STS_BF    = 0;
  localparam int PIN_SDO_DIR = 0;
  localparam int PIN_SCK_DIR = 1;
  localparam int PIN_SS_DIR  = 2;
  localparam int PIN_SDO_LAT = 4;
  localparam int PIN_SCK_LAT = 5;
  localparam int PIN_SS_LAT  = 6;
  localparam int PIN_LVL_LSB = 8;
  localparam int EVT_DONE    = 0;

  // synchronised input vector order
  localparam int IN_SDI = 0;
  localparam int IN_SCK = 1;
  localparam int IN_SS  = 2;
  localparam int IN_SDO = 3;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] STATUS_RST  = 8'h00;
  localparam logic [7:0] PINS_RST    = 8'h07;

  // ************************************************************
  // mode codes and master half periods in core clocks
  // ************************************************************
  localparam logic [3:0] MODE_DIV4    = 4'h0;
  localparam logic [3:0] MODE_DIV16   = 4'h1;
  localparam logic [3:0] MODE_DIV64   = 4'h2;
  localparam logic [3:0] MODE_TIMER   = 4'h3;
  localparam logic [3:0] MODE_SLV_SEL = 4'h4;
  localparam logic [3:0] MODE_SLV_NOS = 4'h5;
  localparam logic [5:0] HALF_DIV4    = 6'h02;
  localparam logic [5:0] HALF_DIV16   = 6'h08;
  localparam logic [5:0] HALF_DIV64   = 6'h20;

  // ************************************************************
  // types
  // ************************************************************
  typedef struct packed {
    logic out;
    logic oe;
  } ssp_pin_t;

  typedef enum logic {ST_IDLE, ST_SHIFT} ssp_state_t;

endpackage

// *** ssp_port.sv ***
// spi port engine: master and slave shifting, buffer, flags, pin muxing
// assumes an Avalon-MM master on core_clk and raw pad levels on the inputs
//
// Implementation choices: the Avalon-MM slave port and the address map.
`timescale 1ns/100ps
module ssp_port #(
  parameter int DATA_BITS = 8                  // bits per transfer
) (
  input  wire logic              core_clk,        // 40 MHz core clock
  input  wire logic              reset_n,         // async reset, low active
  input  wire logic [4:0]        avs_address,     // byte address
  input  wire logic              avs_read,        // read request
  input  wire logic              avs_write,       // write request
  input  wire logic [31:0]       avs_writedata,   // write data
  input  wire logic [3:0]        avs_byteenable,  // byte lanes
  output logic      [31:0]       avs_readdata,    // read data
  output logic                   avs_waitrequest, // stall
  input  wire logic              serialInPin,     // serial data in pad
  input  wire logic              serialOutIn,     // serial-out pad level
  output ssp_pkg::ssp_pin_t      serialOutPin,    // serial-out drive
  input  wire logic              serialClkIn,     // serial clock pad level
  output ssp_pkg::ssp_pin_t      serialClkPin,    // serial clock drive
  input  wire logic              selectIn,        // select pad level
  output ssp_pkg::ssp_pin_t      selectPin,       // select pad drive
  input  wire logic              timerMatch,      // interval timer pulse
  input  wire logic              sleepMode,       // device asleep
  output logic                   transferDone     // sticky done flag
);

  // ************************************************************
  // elaboration checks
  // ************************************************************
  if (DATA_BITS < 4 || DATA_BITS > 16) begin : g_chk
    $error("DATA_BITS must lie between 4 and 16");
  end

  localparam logic [5:0] LAST_K   = 6'(2 * DATA_BITS);
  localparam logic [3:0] LAST_BIT = 4'(DATA_BITS - 1);

  // ************************************************************
  // declarations
  // ************************************************************
  logic [3:0]           sync1;
  logic [3:0]           sync2;
  logic [3:0]           sync3;
  logic [3:0]           pinLevel;
  logic                 rdAck;
  logic                 ctlEnable;
  logic                 clock_idle_polarity;
  logic [3:0]           mode;
  logic                 write_collision_flag;
  logic                 ovf;
  logic                 sample_phase_select;
  logic                 cke;
  logic                 bf;
  logic [7:0]           pinCtl;
  logic [DATA_BITS-1:0] bufData;
  logic [DATA_BITS-1:0] shiftReg;
  logic                 outBit;
  logic                 sckLevel;
  logic                 sckPrev;
  logic [3:0]           bitCnt;
  logic [5:0]           halfCnt;
  logic [5:0]           k;
  ssp_pkg::ssp_state_t  state;

  // ************************************************************
  // pad synchroniser: three stages, change taken when 2 and 3 agree
  // ************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1    <= 4'h0;
      sync2    <= 4'h0;
      sync3    <= 4'h0;
      pinLevel <= 4'h0;
    end else begin
      sync1    <= {serialOutIn, selectIn, serialClkIn, serialInPin};
      sync2    <= sync1;
      sync3    <= sync2;
      pinLevel <= (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & pinLevel);
    end
  end

  // ************************************************************
  // bus decode
  // ************************************************************
  wire hitBuf   = (avs_address == ssp_pkg::OFS_BUFFER);
  wire hitCtl   = (avs_address == ssp_pkg::OFS_CONTROL);
  wire hitSts   = (avs_address == ssp_pkg::OFS_STATUS);
  wire hitPins  = (avs_address == ssp_pkg::OFS_PINS);
  wire hitEvt   = (avs_address == ssp_pkg::OFS_EVENT);
  wire wrLow    = avs_write & avs_byteenable[0];
  wire [7:0] wd = avs_writedata[7:0];
  wire bufWrite = wrLow & hitBuf;
  wire bufRead  = avs_read & rdAck & hitBuf;  // the edge the master takes data

  // ************************************************************
  // mode decode and select handling
  // ************************************************************
  wire isMaster  = (mode[3:2] == 2'b00);                   // [R23]
  wire isSlave   = (mode == ssp_pkg::MODE_SLV_SEL) | (mode == ssp_pkg::MODE_SLV_NOS);
  wire ssDir     = pinCtl[ssp_pkg::PIN_SS_DIR];
  wire ssLat     = pinCtl[ssp_pkg::PIN_SS_LAT];
  wire selActive = ctlEnable & (mode == ssp_pkg::MODE_SLV_SEL) & ssDir & ssLat; // [R15]
  wire selHigh   = selActive & pinLevel[ssp_pkg::IN_SS];
  wire engClear  = ~ctlEnable | selHigh;                   // [R17] [R21]
  wire slaveRun  = ctlEnable & isSlave & ~selHigh;
  wire busy      = (state == ssp_pkg::ST_SHIFT) | (isSlave & (bitCnt != 4'h0));
  wire wrCollide = bufWrite & busy & ctlEnable;            // [R25]
  wire wrAccept  = bufWrite & ~wrCollide;
  wire mStart    = wrAccept & ctlEnable & isMaster;        // [R6]

  // ************************************************************
  // master timing: divided core clock or timer match
  // ************************************************************
  wire [5:0] halfLen = (mode == ssp_pkg::MODE_DIV4)  ? ssp_pkg::HALF_DIV4  :
                       (mode == ssp_pkg::MODE_DIV16) ? ssp_pkg::HALF_DIV16 :
                                                       ssp_pkg::HALF_DIV64;   // [R10]
  wire timerMode = (mode == ssp_pkg::MODE_TIMER);
  wire halfTick  = timerMode ? timerMatch : (halfCnt == halfLen - 6'h01);    // [R28]
  wire mStep     = (state == ssp_pkg::ST_SHIFT) & ~sleepMode & halfTick;     // [R20]
  wire [5:0] kNext    = k + 6'h01;
  wire [5:0] lastK    = LAST_K + {5'h00, ~cke & sample_phase_select};
  wire [5:0] capFirst = (cke ? 6'h01 : 6'h02) + {5'h00, sample_phase_select};               // [R24]
  wire mOutEdge = (cke ? ~kNext[0] : kNext[0]) & (kNext <= LAST_K);          // [R5]
  wire mCapEdge = (kNext >= capFirst) & (kNext[0] == capFirst[0]);
  wire mToggle  = mStep & (kNext <= LAST_K);
  wire mCapture = mStep & mCapEdge;
  wire mDone    = mStep & (kNext == lastK);

  // ************************************************************
  // slave timing: edges of the synchronised external clock
  // ************************************************************
  wire sckNow    = pinLevel[ssp_pkg::IN_SCK];
  wire sckChange = sckNow ^ sckPrev;
  wire sLead     = sckChange & (sckNow != clock_idle_polarity);
  wire sTrail    = sckChange & (sckNow == clock_idle_polarity);
  wire sOut      = slaveRun & (cke ? sTrail : sLead);      // [R5] [R12]
  wire sCapture  = slaveRun & (cke ? sLead : sTrail);
  wire sDone     = sCapture & (bitCnt == LAST_BIT);        // [R13]

  // ************************************************************
  // byte completion
  // ************************************************************
  wire [DATA_BITS-1:0] capShift = {shiftReg[DATA_BITS-2:0], pinLevel[ssp_pkg::IN_SDI]};
  wire [DATA_BITS-1:0] doneByte = (mCapture | sCapture) ? capShift : shiftReg;
  wire byteDone  = mDone | sDone;                          // [R7]
  wire overflow  = sDone & bf & ~bufRead;                  // [R26]
  wire loadBuf   = byteDone & ~overflow;

  // ************************************************************
  // control, status and pin registers
  // ************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctlEnable <= ssp_pkg::CONTROL_RST[ssp_pkg::CTL_EN];  // [R21]
      clock_idle_polarity       <= ssp_pkg::CONTROL_RST[ssp_pkg::CTL_CKP];
      mode      <= ssp_pkg::CONTROL_RST[3:0];
      write_collision_flag      <= ssp_pkg::CONTROL_RST[ssp_pkg::CTL_WRITE_COLLISION_FLAG];
      ovf       <= ssp_pkg::CONTROL_RST[ssp_pkg::CTL_OVF];
      sample_phase_select       <= ssp_pkg::STATUS_RST[ssp_pkg::STS_SMP];
      cke       <= ssp_pkg::STATUS_RST[ssp_pkg::STS_CKE];
      pinCtl    <= ssp_pkg::PINS_RST;
    end else begin
      if (wrLow & hitCtl) begin
        ctlEnable <= wd[ssp_pkg::CTL_EN];
        clock_idle_polarity       <= wd[ssp_pkg::CTL_CKP];
        mode      <= wd[3:0];
      end
      if (wrLow & hitSts) begin
        sample_phase_select <= wd[ssp_pkg::STS_SMP];
        cke <= wd[ssp_pkg::STS_CKE];
      end
      if (wrLow & hitPins) begin
        pinCtl <= wd;
      end
      write_collision_flag <= wrCollide | ((wrLow & hitCtl) ? wd[ssp_pkg::CTL_WRITE_COLLISION_FLAG] : write_collision_flag); // [R25]
      ovf  <= overflow  | ((wrLow & hitCtl) ? wd[ssp_pkg::CTL_OVF]  : ovf);  // [R26]
    end
  end

  // ************************************************************
  // buffer, full bit and done flag; a hardware set beats a clear
  // ************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      bufData      <= '0;
      bf           <= 1'b0;
      transferDone <= 1'b0;
    end else begin
      if (loadBuf) begin
        bufData <= doneByte;                               // [R27]
      end else if (wrAccept) begin
        bufData <= avs_writedata[DATA_BITS-1:0];
      end
      bf <= loadBuf | (bf & ~bufRead);                     // [R27]
      transferDone <= loadBuf |
        ((wrLow & hitEvt) ? wd[ssp_pkg::EVT_DONE] : transferDone);
    end
  end

  // ************************************************************
  // master sequencer and serial clock generator
  // ************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state    <= ssp_pkg::ST_IDLE;
      halfCnt  <= 6'h00;
      k        <= 6'h00;
      sckLevel <= 1'b0;
    end else begin
      case (state)
        ssp_pkg::ST_IDLE: begin
          sckLevel <= clock_idle_polarity;                                 // [R8]
          halfCnt  <= 6'h00;
          k        <= 6'h00;
          if (mStart) begin
            state <= ssp_pkg::ST_SHIFT;
          end
        end
        ssp_pkg::ST_SHIFT: begin
          if (engClear) begin
            state <= ssp_pkg::ST_IDLE;
          end else if (!sleepMode) begin                   // [R20]
            halfCnt <= halfTick ? 6'h00 : halfCnt + 6'h01;
            if (mStep) begin
              k <= kNext;
            end
            if (mToggle) begin
              sckLevel <= ~sckLevel;
            end
            if (mDone) begin
              state <= ssp_pkg::ST_IDLE;
            end
          end
        end
        default: state <= ssp_pkg::ST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // shared shift register, output bit and slave bit counter
  // ************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      shiftReg <= '0;
      outBit   <= 1'b0;
      bitCnt   <= 4'h0;
      sckPrev  <= 1'b0;
    end else begin
      sckPrev <= sckNow;
      if (engClear) begin
        bitCnt <= 4'h0;                                    // [R17]
      end else if (sCapture) begin
        bitCnt <= sDone ? 4'h0 : bitCnt + 4'h1;
      end
      if (wrAccept & ctlEnable) begin
        shiftReg <= avs_writedata[DATA_BITS-1:0];
        outBit   <= avs_writedata[DATA_BITS-1];            // [R9] [R11]
      end else begin
        if ((mStep & mOutEdge) | sOut) begin
          outBit <= shiftReg[DATA_BITS-1];                 // [R5] [R9]
        end
        if (mCapture | sCapture) begin
          shiftReg <= capShift;
        end
      end
    end
  end

  // ************************************************************
  // pad drivers: serial-out, and the clock in master modes, from the serial port when enabled; general I/O otherwise
  // ************************************************************
  wire sdoDir  = pinCtl[ssp_pkg::PIN_SDO_DIR];
  wire sckDir  = pinCtl[ssp_pkg::PIN_SCK_DIR];
  wire sdoFloat = selActive & selectIn;                    // [R16]
  assign serialOutPin.out = ctlEnable ? outBit : pinCtl[ssp_pkg::PIN_SDO_LAT]; // [R1]
  assign serialOutPin.oe  = ~sdoDir & ~(ctlEnable & sdoFloat);                 // [R19]
  assign serialClkPin.out = (ctlEnable & isMaster) ? sckLevel :
                            pinCtl[ssp_pkg::PIN_SCK_LAT];
  assign serialClkPin.oe  = ~sckDir;                       // [R3]
  assign selectPin.out    = ssLat;
  assign selectPin.oe     = ~ssDir;

  // ************************************************************
  // register read-back, one wait state on reads
  // ************************************************************
  wire [7:0] ctlRead = {write_collision_flag, ovf, ctlEnable, clock_idle_polarity, mode};
  wire [7:0] stsRead = {sample_phase_select, cke, 5'h00, bf};
  wire [31:0] rdMux =
    hitBuf  ? {{(32-DATA_BITS){1'b0}}, bufData} :
    hitCtl  ? {24'h000000, ctlRead} :
    hitSts  ? {24'h000000, stsRead} :
    hitPins ? {20'h00000, pinLevel, pinCtl} :
    hitEvt  ? {31'h00000000, transferDone} : 32'h00000000;
  assign avs_waitrequest = avs_read & ~rdAck;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdAck        <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      rdAck <= avs_read & ~rdAck;
      if (avs_read & ~rdAck) begin
        avs_readdata <= rdMux;
      end
    end
  end

  // ************************************************************
  // assertions and covers
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  idle_clock_a: assert property ((state == ssp_pkg::ST_IDLE) ##1 (state == ssp_pkg::ST_IDLE) // [R8]
    |-> sckLevel == $past(clock_idle_polarity)) else $error("serial clock not at idle level");
  start_write_a: assert property (mStart |=> state == ssp_pkg::ST_SHIFT && k == 6'h00) // [R6]
    else $error("master did not start on buffer write");
  collide_a: assert property (wrCollide |=> write_collision_flag && bufData == $past(bufData) // [R25]
    || $past(loadBuf)) else $error("collision not flagged");
  overflow_a: assert property (overflow |=> ovf && !$changed(bufData)) // [R26]
    else $error("overflow not flagged or byte kept");
  done_same_a: assert property (loadBuf |=> bf && transferDone // [R27]
    && bufData == $past(doneByte)) else $error("completion updates split");
  select_clear_a: assert property (selHigh |=> bitCnt == 4'h0) // [R17]
    else $error("bit counter not cleared by select");
  select_float_a: assert property (ctlEnable && sdoFloat |-> !serialOutPin.oe) // [R16]
    else $error("serial-out driven while deselected");
  sleep_freeze_a: assert property ((state == ssp_pkg::ST_SHIFT) && sleepMode && !engClear // [R20]
    |=> $stable(k) && $stable(sckLevel)) else $error("master moved during sleep");
  msb_first_a: assert property (wrAccept && ctlEnable // [R9]
    |=> outBit == $past(avs_writedata[DATA_BITS-1])) else $error("first bit not msb");
  disable_abort_a: assert property (!ctlEnable |=> state == ssp_pkg::ST_IDLE // [R21]
    && bitCnt == 4'h0) else $error("disabled port still shifting");
  gpio_pins_a: assert property (!ctlEnable // [R1]
    |-> serialOutPin.out == pinCtl[ssp_pkg::PIN_SDO_LAT]) else $error("pins not general I/O");

  master_byte_c: cover property (mStart ##[1:300] mDone);
  slave_byte_c: cover property (sDone && !overflow);
  slave_ovf_c: cover property (overflow);
  sleep_hold_c: cover property ((state == ssp_pkg::ST_SHIFT) && sleepMode);

endmodule

// *** ssp_peer.sv ***
// spi peer model answering a master transfer of the serial port
// assumes clock and data lines already resolved by the bench
`timescale 1ns/100ps
module ssp_peer (
  input  wire logic       sck,    // serial clock line
  input  wire logic       mosi,   // data from the port
  input  wire logic       clock_idle_polarity,    // idle level
  input  wire logic       cke,    // edge select
  input  wire logic [7:0] txByte, // byte sent back
  input  wire logic       load,   // frame start
  output logic            miso,   // data to the port
  output logic      [7:0] rxByte  // byte captured
);
  logic [7:0] sh;
  // ******************************
  // frame start and shifting
  // ******************************
  initial miso = 1'b0;
  // first bit early only when edge select is set
  always @(posedge load) begin
    sh = txByte;
    miso = cke ? sh[7] : ~miso;
    if (cke)
      sh = {sh[6:0], 1'b0};
  end
  // capture on one edge, shift on the other, msb first
  always @(sck) begin
    if ((sck ^ clock_idle_polarity) == cke)
      rxByte = {rxByte[6:0], mosi};
    else begin
      miso = sh[7];
      sh = {sh[6:0], ~sh[0]};
    end
  end
endmodule

// *** testbench.sv ***
// self-checking bench: register bus, master and slave transfers
// assumes ssp_pkg and the peer model are compiled first
`timescale 1ns/100ps
module testbench;
  logic              core_clk = 1'b0;
  logic              reset_n = 1'b0;
  logic              avs_read, avs_write, timerMatch, sleepMode, tbSck, tbSdi, tbSel;
  logic              slv, tmrOn, peerLoad, clock_idle_polarity, cke, avs_waitrequest, transferDone;
  logic [4:0]        avs_address;
  logic [31:0]       avs_writedata, avs_readdata, rdv;
  logic [7:0]        peerTx, peerRx, got;
  wire               peerMiso, sdoLine, sckLine;
  ssp_pkg::ssp_pin_t serialOutPin, serialClkPin, selectPin;
  int                err_total = 0, compares = 0, cyc = 0, n, w;
  // pad levels: serial-out pulled up when released, clock taken from tbSck when released
  assign sdoLine = serialOutPin.oe ? serialOutPin.out : 1'b1;
  assign sckLine = serialClkPin.oe ? serialClkPin.out : tbSck;
  ssp_port dut (.core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .serialInPin(slv ? tbSdi : peerMiso), .serialOutIn(sdoLine), .serialOutPin(serialOutPin),
    .serialClkIn(sckLine), .serialClkPin(serialClkPin), .selectIn(tbSel),
    .selectPin(selectPin), .timerMatch(timerMatch), .sleepMode(sleepMode),
    .transferDone(transferDone));
  ssp_peer peer (.sck(sckLine), .mosi(sdoLine), .clock_idle_polarity(clock_idle_polarity), .cke(cke), .txByte(peerTx),
    .load(peerLoad), .miso(peerMiso), .rxByte(peerRx));
  // ******************************
  // clock, timer pulses, timeout
  // ******************************
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    timerMatch <= tmrOn && (cyc % 6 == 0);
    if (cyc == 60000) begin
      err_total++;
      stop_test();
    end
  end
  // ******************************
  // bus and compare tasks
  // ******************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rdv = avs_readdata;
    avs_read <= 1'b0;
    chk(rdv, {24'h0, e});
  endtask
  task automatic waitDone;
    w = 0;
    while (transferDone !== 1'b1 && w < 3000) begin
      @(posedge core_clk);
      w++;
    end
    chk(transferDone, 1'b1);
  endtask
  // disable, set up, then enable again
  task automatic cfg(input logic [7:0] c, input logic [7:0] s, input logic [7:0] p);
    wr(ssp_pkg::OFS_CONTROL, c & 8'hDF);
    wr(ssp_pkg::OFS_STATUS, s);
    wr(ssp_pkg::OFS_PINS, p);
    wr(ssp_pkg::OFS_CONTROL, c);
  endtask
  // master byte exchange; ext 1 sleeps midway, ext 2 collides
  task automatic xfer(input logic p, e, input int ext, input logic [7:0] tx, rx);
    clock_idle_polarity = p;
    cke = e;
    cfg({3'b001, p, 4'h1}, {1'b0, e, 6'h0}, 8'h44);
    repeat (2) @(posedge core_clk);
    chk(serialClkPin.out, p);
    peerTx = rx;
    peerLoad = 1'b1;
    @(posedge core_clk);
    peerLoad = 1'b0;
    wr(ssp_pkg::OFS_BUFFER, tx);
    repeat (30) @(posedge core_clk);
    if (ext == 1) begin
      sleepMode <= 1'b1;
      repeat (2) @(posedge core_clk);
      got[0] = serialClkPin.out;
      repeat (40) @(posedge core_clk);
      chk(serialClkPin.out, got[0]);
      sleepMode <= 1'b0;
    end
    if (ext == 2)
      wr(ssp_pkg::OFS_BUFFER, 8'hFF);
    waitDone();
    rd(ssp_pkg::OFS_CONTROL, {ext == 2, 2'b01, p, 4'h1});
    rd(ssp_pkg::OFS_STATUS, {1'b0, e, 6'h01});
    rd(ssp_pkg::OFS_BUFFER, rx);
    rd(ssp_pkg::OFS_STATUS, {1'b0, e, 6'h00});
    chk(peerRx, tx);
    wr(ssp_pkg::OFS_CONTROL, {3'b001, p, 4'h1});
    wr(ssp_pkg::OFS_EVENT, 8'h00);
  endtask
  // bench as master of a slave-mode port, nb bits msb first
  task automatic sbyte(input logic [7:0] d, input int nb);
    for (int i = 7; i >= 8 - nb; i--) begin
      tbSdi <= d[i];
      repeat (8) @(posedge core_clk);
      tbSck <= 1'b1;
      repeat (8) @(posedge core_clk);
      got[i] = serialOutPin.out;
      tbSck <= 1'b0;
      repeat (8) @(posedge core_clk);
    end
  endtask
  task automatic stop_test;
    if (err_total == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ******************************
  // main sequence
  // ******************************
  initial begin
    {avs_read, avs_write, timerMatch, sleepMode, tbSck, tbSdi, slv, tmrOn, peerLoad} = '0;
    {clock_idle_polarity, cke, tbSel, avs_address, avs_writedata, peerTx} = 48'h1_0000_0000_00;
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(ssp_pkg::OFS_CONTROL, ssp_pkg::CONTROL_RST);
    rd(ssp_pkg::OFS_STATUS, ssp_pkg::STATUS_RST);
    rd(5'h14, 8'h00);
    wr(ssp_pkg::OFS_PINS, 8'h64);
    @(posedge core_clk);
    chk(serialClkPin, 2'b11);
    for (int i = 0; i < 4; i++)
      xfer(i[1], ~i[0], 0, 8'hA5 ^ i[7:0], 8'h3C ^ i[7:0]);
    xfer(1'b0, 1'b1, 1, 8'h81, 8'h7E);
    xfer(1'b1, 1'b1, 2, 8'h0F, 8'hF0);
    tmrOn = 1'b1;
    slv = 1'b1;
    for (int m = 0; m < 4; m++) begin
      cfg({4'h2, m[3:0]}, 8'h40, 8'h44);
      wr(ssp_pkg::OFS_BUFFER, 8'h55);
      for (w = 0; serialClkPin.out !== 1'b1 && w < 300; w++) @(posedge core_clk);
      for (n = 0; serialClkPin.out === 1'b1 && n < 100; n++) @(posedge core_clk);
      chk(n, m == 3 ? 6 : ssp_pkg::HALF_DIV4 << (2 * m));
      waitDone();
      rd(ssp_pkg::OFS_BUFFER, 8'h00);
      wr(ssp_pkg::OFS_EVENT, 8'h00);
    end
    slv = 1'b1;
    clock_idle_polarity = 1'b0;
    cfg(8'h24, 8'h00, 8'h46);
    wr(ssp_pkg::OFS_BUFFER, 8'h96);
    tbSel <= 1'b0;
    sbyte(8'h5A, 8);
    chk(got, 8'h96);
    waitDone();
    sbyte(8'hC3, 8);
    rd(ssp_pkg::OFS_CONTROL, 8'h64);
    rd(ssp_pkg::OFS_BUFFER, 8'h5A);
    chk(serialOutPin.oe, 1'b1);
    tbSel <= 1'b1;
    @(posedge core_clk);
    @(posedge core_clk);
    chk(serialOutPin.oe, 1'b0);
    wr(ssp_pkg::OFS_CONTROL, 8'h24);
    wr(ssp_pkg::OFS_EVENT, 8'h00);
    tbSel <= 1'b0;
    sbyte(8'hFF, 3);
    tbSel <= 1'b1;
    repeat (8) @(posedge core_clk);
    tbSel <= 1'b0;
    sbyte(8'hA5, 8);
    waitDone();
    rd(ssp_pkg::OFS_BUFFER, 8'hA5);
    rd(ssp_pkg::OFS_CONTROL, 8'h24);
    slv = 1'b0;
    cfg(8'h22, 8'h40, 8'h44);
    wr(ssp_pkg::OFS_BUFFER, 8'hAA);
    repeat (100) @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(ssp_pkg::OFS_CONTROL, 8'h00);
    chk(serialClkPin, 2'b00);
    stop_test();
  end
endmodule
